// ===== hdl/dpw_slave.v
/*
 * two-wire serial slave of a 256-position digital potentiometer: receives
 * address, instruction and wiper bytes, returns the wiper on reads.
 * assumes scl and sda arrive from pins (open drain, pulled up outside) and
 * that the bus clock is much slower than clk.
 */
// Summary of operation
// [RULE_01] two-wire slave only while interface select high
// [RULE_02] address 010110 plus address select pin
// [RULE_03] start marks next byte as address
// [RULE_04] ack match on ninth clock, else idle; the code waits in ST_WAIT, busy high, until stop or start
// [RULE_05] direction bit high reads, low writes
// [RULE_06] instruction byte follows address; msb ignored
// [RULE_07] midscale bit overwrites wiper with midscale
// [RULE_08] shutdown opens A, shorts wiper, keeps register
// [RULE_09] writes accepted in shutdown; resume latest setting
// [RULE_10] five low instruction bits ignored
// [RULE_11] data byte acknowledged and loaded into wiper
// [RULE_12] sda changes only while scl low
// [RULE_13] read returns wiper right after address ack
// [RULE_14] stop detected releases the bus
// [RULE_15] master nacks read then forms stop
// [RULE_16] further data bytes reuse the same instruction
// [RULE_17] new instruction needs a new transfer
// [RULE_18] repeated reads return wiper every byte
// [RULE_19] midscale code is 0x80
`timescale 1ns/1ps
`include "dpw_consts.vh"
module dpw_slave
(
    input  wire       clk,
    input  wire       rst_n,
    input  wire       interface_select_pin,
    input  wire       address_select_pin,
    input  wire       scl_i,
    input  wire       sda_i,
    output wire       sda_o,
    output wire       sda_oe,
    output wire [7:0] wiper_register,
    output wire [7:0] wiper_tap,
    output wire       term_a_open,
    output wire       wiper_to_b,
    output wire       busy
);
    // ==========================================================
    // synchronisers and bus conditions
    wire scl_s;
    wire sda_s;
    wire sel_s;
    wire ads_s;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;

    dpw_sync #(.RST_VAL(1'b1)) u_sync_scl (.clk(clk), .rst_n(rst_n), .d(scl_i), .q(scl_s));
    dpw_sync #(.RST_VAL(1'b1)) u_sync_sda (.clk(clk), .rst_n(rst_n), .d(sda_i), .q(sda_s));
    dpw_sync #(.RST_VAL(1'b0)) u_sync_sel
    (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (interface_select_pin),
        .q     (sel_s)
    );
    dpw_sync #(.RST_VAL(1'b0)) u_sync_ads
    (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (address_select_pin),
        .q     (ads_s)
    );

    dpw_edge u_edge
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .scl       (scl_s),
        .sda       (sda_s),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    // ==========================================================
    // state machine
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_ADDR = 6'h02;
    localparam [5:0] ST_INS  = 6'h04;
    localparam [5:0] ST_DATA = 6'h08;
    localparam [5:0] ST_READ = 6'h10;
    localparam [5:0] ST_WAIT = 6'h20;

    reg [5:0] state_q;
    reg [7:0] shift_q;
    reg [3:0] bit_q;
    reg       ack_q;
    reg       drv_q;
    reg       drv_d;
    reg [7:0] wiper_q;
    reg       sd_q;
    reg       rs_q;
    reg       mack_q;

    wire       ninth    = (bit_q == `DPW_ACK_SLOT);
    wire [7:0] rx_byte  = {shift_q[6:0], sda_s};

    // full byte seen at ninth-bit boundary: bit_q counts received bits
    wire       addr_hit = (shift_q[7:2] == `DPW_ADDR_HI) && (shift_q[1] == ads_s); // RULE_02

    // ==========================================================
    // helpers
    // a read byte restarts from the wiper after our ack or the master's
    function reload_rd;
        input       ack;
        input [3:0] cnt;
        input       mack;
        begin
            reload_rd = ack || (cnt == 4'h0 && mack);
        end
    endfunction

    // midscale request carried by the instruction byte
    function ins_midscale;
        input [7:0] ins;
        begin
            ins_midscale = ins[`DPW_INS_RS_BIT];
        end
    endfunction

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            bit_q   <= 4'h0;
            ack_q   <= 1'b0;
            drv_q   <= 1'b0;
            wiper_q <= `DPW_WIPER_RST;
            sd_q    <= 1'b0;
            rs_q    <= 1'b0;
            mack_q  <= 1'b0;
        end
        else if (!sel_s)
        begin
            state_q <= ST_IDLE; // RULE_01
            ack_q   <= 1'b0;
            drv_q   <= 1'b0;
        end
        else if (stop_det)
        begin
            state_q <= ST_IDLE; // RULE_14
            ack_q   <= 1'b0;
            drv_q   <= 1'b0;
        end
        else if (start_det)
        begin
            state_q <= ST_ADDR; // RULE_03
            bit_q   <= 4'h0;
            ack_q   <= 1'b0;
            drv_q   <= 1'b0;
        end
        else
        begin
            // sample on rising scl
            if (scl_rise && !(state_q[0] || state_q[5]))
            begin
                if (ninth)
                begin
                    mack_q <= ~sda_s;
                end
                else
                begin
                    shift_q <= rx_byte;
                end
                bit_q <= ninth ? 4'h0 : bit_q + 4'h1;
            end
            // drive on falling scl so sda only moves while scl low
            if (scl_fall)
            begin
                ack_q <= 1'b0;
                drv_q <= 1'b0; // RULE_12
                if (ninth && !ack_q)
                begin
                    case (state_q)
                        ST_ADDR:
                        begin
                            if (addr_hit)
                            begin
                                ack_q <= 1'b1; // RULE_04
                                if (shift_q[0])
                                begin
                                    state_q <= ST_READ; // RULE_05
                                end
                                else
                                begin
                                    state_q <= ST_INS;
                                end
                            end
                            else
                            begin
                                state_q <= ST_WAIT;
                            end
                        end
                        ST_INS:
                        begin
                            ack_q <= 1'b1;
                            // msb and low five bits unused
                            rs_q  <= ins_midscale(shift_q); // RULE_06 RULE_10
                            sd_q  <= shift_q[`DPW_INS_SD_BIT]; // RULE_08 RULE_09
                            if (ins_midscale(shift_q))
                            begin
                                wiper_q <= `DPW_WIPER_MID; // RULE_07 RULE_19
                            end
                            state_q <= ST_DATA;
                        end
                        ST_DATA:
                        begin
                            ack_q   <= 1'b1; // RULE_11
                            // same instruction held for every further byte
                            wiper_q <= rs_q ? `DPW_WIPER_MID : shift_q; // RULE_16
                        end
                        ST_READ:
                        begin
                            // let go of sda so the master can acknowledge
                            state_q <= ST_READ;
                        end
                        default:
                        begin
                            state_q <= state_q;
                        end
                    endcase
                end
                else if (state_q == ST_READ)
                begin
                    drv_q <= drv_d; // RULE_13 RULE_18
                end
            end
        end
    end

    // ==========================================================
    // read path: drive bit of wiper, release on ack slot; master nack ends reads
    reg [7:0] rd_q;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_q <= 8'h00;
        end
        else if (scl_fall && state_q == ST_READ)
        begin
            if (reload_rd(ack_q, bit_q, mack_q))
            begin
                rd_q <= wiper_q; // RULE_18
            end
            else if (bit_q != 4'h0)
            begin
                rd_q <= {rd_q[6:0], 1'b1};
            end
        end
    end

    // ==========================================================
    // next read bit on sda, inverted because a set enable pulls low
    always @*
    begin
        drv_d = 1'b0;
        if (bit_q == 4'h0 && !(ack_q || mack_q))
        begin
            drv_d = 1'b0; // RULE_15
        end
        else if (reload_rd(ack_q, bit_q, mack_q))
        begin
            drv_d = ~wiper_q[7];
        end
        else if (bit_q < `DPW_ACK_SLOT)
        begin
            drv_d = ~rd_q[6];
        end
    end

    // ==========================================================
    // resistor array code: shutdown grounds the tap, register kept
    reg [7:0] tap_q;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tap_q <= `DPW_WIPER_RST;
        end
        else
        begin
            tap_q <= sd_q ? 8'h00 : wiper_q; // RULE_08 RULE_09
        end
    end

    // ==========================================================
    // outputs
    assign sda_o          = 1'b0;
    assign sda_oe         = ack_q | drv_q;
    assign wiper_register = wiper_q;
    assign wiper_tap      = tap_q; // RULE_08 RULE_09
    assign term_a_open    = sd_q;
    assign wiper_to_b     = sd_q;
    assign busy           = ~state_q[0];
endmodule

// ===== hdl/dpw_consts.vh
/*
 * constants for the two-wire wiper slave: address, instruction byte fields,
 * reset values.
 * assumes inclusion by the design files of the wiper slave only.
 */
`ifndef DPW_CONSTS_VH
`define DPW_CONSTS_VH

// ==========================================================
// slave address
`define DPW_ADDR_HI        6'h16
// ==========================================================
// instruction byte fields
`define DPW_INS_RS_BIT     6
`define DPW_INS_SD_BIT     5
// ==========================================================
// bit counter value of the acknowledge slot
`define DPW_ACK_SLOT       4'h8
// ==========================================================
// midscale and reset values
`define DPW_WIPER_MID      8'h80
`define DPW_WIPER_RST      8'h80

`endif

// ===== hdl/dpw_sync.v
/*
 * two flip-flop synchroniser for one asynchronous level.
 * assumes clk is the block clock; the first stage is read only by the second.
 */
`timescale 1ns/1ps
module dpw_sync
#(
    parameter RST_VAL = 1'b1
)
(
    input  wire clk,
    input  wire rst_n,
    input  wire d,
    output reg  q
);
    reg meta_q;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ===== hdl/dpw_edge.v
/*
 * edge and bus condition detector for synchronised scl and sda.
 * assumes both inputs are already synchronised to clk.
 */
`timescale 1ns/1ps
module dpw_edge
(
    input  wire clk,
    input  wire rst_n,
    input  wire scl,
    input  wire sda,
    output wire scl_rise,
    output wire scl_fall,
    output wire start_det,
    output wire stop_det
);
    reg scl_q;
    reg sda_q;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    assign scl_rise  = scl & ~scl_q;
    assign scl_fall  = ~scl & scl_q;
    assign start_det = scl & scl_q & sda_q & ~sda;
    assign stop_det  = scl & scl_q & ~sda_q & sda;
endmodule

// ===== test/dpw_master_model.sv
/* two-wire bus master model for the wiper slave bench.
   assumes a pull-up on sda outside; clk times every bus edge. */
`timescale 1ns/1ps
module dpw_master_model
(
    input  wire  clk,
    input  wire  sda,
    output logic scl,
    output logic pull
);
    // ==========================================================
    // bus timing: 800 ns bit, 600 ns low, 200 ns high
    initial scl = 1'b1;
    initial pull = 1'b0;
    task w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task start();
        w(4);
        pull = 1'b1;
        w(2);
        scl = 1'b0;
    endtask
    task stop();
        w(2);
        pull = 1'b1;
        w(4);
        scl = 1'b1;
        w(2);
        pull = 1'b0;
        w(4);
    endtask
    task xbit(input logic b, output logic r);
        w(2);
        pull = ~b;
        w(4);
        scl = 1'b1;
        w(1);
        r = sda;
        w(1);
        scl = 1'b0;
    endtask
    // ==========================================================
    // eight bits msb first, then the acknowledge clock
    task xbyte(input logic [7:0] d, input logic ab, output logic [7:0] r, output logic ak);
        for (int i = 7; i >= 0; i--)
            xbit(d[i], r[i]);
        xbit(ab, ak);
    endtask
endmodule

// ===== test/dpw_slave_properties.sv
/* port assertions for the wiper slave.
   assumes one clock domain and rst_n asynchronous, active low. */
`timescale 1ns/1ps
module dpw_slave_properties
(
    input wire       clk,
    input wire       rst_n,
    input wire       interface_select_pin,
    input wire       address_select_pin,
    input wire       scl_i,
    input wire       sda_i,
    input wire       sda_o,
    input wire       sda_oe,
    input wire [7:0] wiper_register,
    input wire [7:0] wiper_tap,
    input wire       term_a_open,
    input wire       wiper_to_b,
    input wire       busy
);
    // ==========================================================
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    AST_OE_LOW_SCL: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("sda drive changed while scl high");
    AST_TAP: assert property ($stable(wiper_register) && $stable(term_a_open)
        |-> wiper_tap == (term_a_open ? 8'h00 : wiper_register))
        else $error("tap does not follow wiper");
    AST_SHUT_KEEP: assert property ($rose(term_a_open) |-> $stable(wiper_register))
        else $error("shutdown disturbed wiper");
    AST_B_SHORT: assert property (wiper_to_b == term_a_open)
        else $error("wiper short differs from open terminal");
    AST_WIPER_ON_FALL: assert property ($changed(wiper_register) |-> busy && !scl_i)
        else $error("wiper changed outside a transfer");
    AST_IDLE_DIS: assert property (!interface_select_pin [*5] |-> !sda_oe)
        else $error("sda driven while interface off");
    AST_START_BUSY: assert property ($fell(sda_i) && scl_i && $past(scl_i)
        && interface_select_pin |-> ##[1:6] busy)
        else $error("start not seen");
    AST_STOP_FREE: assert property ($rose(sda_i) && scl_i && $past(scl_i)
        |-> ##[1:6] (!busy && !sda_oe))
        else $error("stop did not release bus");
endmodule
bind dpw_slave dpw_slave_properties dpw_slave_properties_inst (.clk(clk), .rst_n(rst_n),
    .interface_select_pin(interface_select_pin), .address_select_pin(address_select_pin),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy),
    .wiper_register(wiper_register), .wiper_tap(wiper_tap), .term_a_open(term_a_open),
    .wiper_to_b(wiper_to_b));

// ===== test/dpw_slave_tb_top.sv
/* self-checking bench for the wiper slave.
   assumes the master model and checker are compiled alongside. */
`timescale 1ns/1ps
module dpw_slave_tb_top;
    logic       clk;
    logic       rst_n;
    logic       isp;
    logic       asp;
    wire        scl;
    wire        pull;
    wire        sda_oe;
    wire        sda_o;
    wire        sda;
    wire  [7:0] wiper;
    wire  [7:0] tap;
    wire        a_open;
    wire        to_b;
    wire        busy;
    int         error_cnt = 0;
    int         checks_done = 0;
    // ==========================================================
    // open-drain bus with pull-up
    assign sda = ~(pull | (sda_oe & ~sda_o));
    initial clk = 1'b0;
    always #50 clk = ~clk;
    dpw_master_model dpw_master_model_inst (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
    dpw_slave dpw_slave_inst
    (
        .clk                 (clk),
        .rst_n               (rst_n),
        .interface_select_pin(isp),
        .address_select_pin  (asp),
        .scl_i               (scl),
        .sda_i               (sda),
        .sda_o               (sda_o),
        .sda_oe              (sda_oe),
        .wiper_register      (wiper),
        .wiper_tap           (tap),
        .term_a_open         (a_open),
        .wiper_to_b          (to_b),
        .busy                (busy)
    );
    // ==========================================================
    // tasks
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task close_out();
        $display("errors %0d, checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, i, d0, d1, input logic k);
        logic [7:0] r;
        logic       ak;
        dpw_master_model_inst.start();
        dpw_master_model_inst.xbyte(a, 1'b1, r, ak);
        chk({7'h00, ak}, {7'h00, k});
        dpw_master_model_inst.xbyte(i, 1'b1, r, ak);
        chk({7'h00, ak}, {7'h00, k});
        dpw_master_model_inst.xbyte(d0, 1'b1, r, ak);
        chk({7'h00, ak}, {7'h00, k});
        dpw_master_model_inst.xbyte(d1, 1'b1, r, ak);
        chk({7'h00, ak}, {7'h00, k});
        dpw_master_model_inst.stop();
    endtask
    task wr_ins(input logic [7:0] a, i);
        logic [7:0] r;
        logic       ak;
        dpw_master_model_inst.start();
        dpw_master_model_inst.xbyte(a, 1'b1, r, ak);
        chk({7'h00, ak}, 8'h00);
        dpw_master_model_inst.xbyte(i, 1'b1, r, ak);
        chk({7'h00, ak}, 8'h00);
        dpw_master_model_inst.stop();
    endtask
    task rd(input logic [7:0] a, e);
        logic [7:0] r;
        logic       ak;
        dpw_master_model_inst.start();
        dpw_master_model_inst.xbyte(a, 1'b1, r, ak);
        chk({7'h00, ak}, 8'h00);
        dpw_master_model_inst.xbyte(8'hFF, 1'b0, r, ak);
        chk(r, e);
        dpw_master_model_inst.xbyte(8'hFF, 1'b1, r, ak);
        chk(r, e);
        dpw_master_model_inst.stop();
    endtask
    // ==========================================================
    // tests
    initial
    begin
        #2000000;
        error_cnt++;
        close_out();
    end
    initial
    begin
        rst_n = 1'b0;
        isp = 1'b1;
        asp = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(wiper, 8'h80);
        chk({7'h00, sda_o}, 8'h00);
        wr(8'h58, 8'h9F, 8'h3C, 8'hA5, 1'b0);
        chk(wiper, 8'hA5);
        chk({7'h00, busy}, 8'h00);
        rd(8'h59, 8'hA5);
        wr(8'h5A, 8'h00, 8'h01, 8'h02, 1'b1);
        chk(wiper, 8'hA5);
        asp = 1'b1;
        wr(8'h5A, 8'h20, 8'h11, 8'h12, 1'b0);
        chk({7'h00, a_open}, 8'h01);
        chk(tap, 8'h00);
        chk(wiper, 8'h12);
        chk({7'h00, to_b}, 8'h01);
        wr_ins(8'h5A, 8'h00);
        chk(tap, 8'h12);
        chk({7'h00, to_b}, 8'h00);
        wr(8'h5A, 8'h00, 8'h21, 8'h22, 1'b0);
        chk({7'h00, a_open}, 8'h00);
        chk(tap, 8'h22);
        wr(8'h5A, 8'h40, 8'h55, 8'h66, 1'b0);
        chk(wiper, 8'h80);
        isp = 1'b0;
        wr(8'h5A, 8'h00, 8'h33, 8'h44, 1'b1);
        chk(wiper, 8'h80);
        close_out();
    end
endmodule
